/* hw/filt_ready_map.svh */
// register offsets, field positions and reset values of the filter and pin-function bytes
`ifndef FILT_READY_MAP_SVH
`define FILT_READY_MAP_SVH
`define FILTER_POLE_SELECT_ADDR 8'h11
`define SHARED_PIN_FUNCTION_CTRL_ADDR 8'h12
`define FILTER_POLE_SELECT_RESET 8'h00
`define SHARED_PIN_FUNCTION_CTRL_RESET 8'h00
`define HP_MSB 7
`define HP_LSB 4
`define LP_MSB 2
`define LP_LSB 0
`define PIN_FN_MSB 1
`define PIN_FN_LSB 0
`define PIN_FN_DATA_READY 2'h1
`endif

/* hw/filt_ready_pkg.sv */
// types shared by the filter and data-ready register bank
package filt_ready_pkg;
   typedef struct packed {
      logic [3:0] highpass_pole_sel;
      logic zero_bit;
      logic [2:0] lowpass_pole_sel;
   } filter_byte_t;
   typedef struct packed {
      logic wr_en;
      logic rd_en;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;
   typedef enum logic [1:0] {
      PIN_SENSE,
      PIN_DRIVE_READY,
      PIN_RESERVED
   } pin_mode_t;
endpackage

/* hw/filt_ready_regs.sv */
// filter pole select and shared-pin data-ready register bank
`include "filt_ready_map.svh"
`timescale 1ns/1ns
`default_nettype none
module filt_ready_regs (
   input wire logic CORE_CLK_I,
   input wire logic RST_I,
   input wire filt_ready_pkg::reg_req_t REQ_I,
   input wire logic NEW_DATA_I,
   input wire logic RATE_DATA_READ_I,
   input wire logic SHARED_SELECT_PIN_I,
   output logic [7:0] RDATA_O,
   output logic [3:0] HIGHPASS_POLE_SEL_O,
   output logic [2:0] LOWPASS_POLE_SEL_O,
   output logic SHARED_SELECT_PIN_O,
   output logic SHARED_SELECT_PIN_OE_N_O,
   output logic ANALOG_ENABLE_O
);
   import filt_ready_pkg::*;

   filter_byte_t filter_q;
   filter_byte_t filter_d;
   logic [1:0] pin_fn_q;
   logic [1:0] pin_fn_d;
   logic ready_q;
   logic ready_d;
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;
   logic pin_o_q;
   logic pin_o_d;
   logic oe_n_q;
   logic oe_n_d;
   logic analog_q;
   logic analog_d;
   pin_mode_t mode;

   // code 11 is reserved: release the pad rather than guess a drive level
   always_comb begin
      case (pin_fn_q)
         2'h0, 2'h2: begin
            mode = PIN_SENSE;
         end
         2'h1: begin
            mode = PIN_DRIVE_READY;
         end
         default: begin
            mode = PIN_RESERVED;
         end
      endcase
   end

   always_comb begin
      filter_d = filter_q;
      pin_fn_d = pin_fn_q;
      rdata_d = 8'h00;
      if (REQ_I.wr_en && REQ_I.addr == `FILTER_POLE_SELECT_ADDR) begin
         filter_d = REQ_I.wdata;
         filter_d.zero_bit = 1'b0;
      end
      if (REQ_I.wr_en && REQ_I.addr == `SHARED_PIN_FUNCTION_CTRL_ADDR) begin
         pin_fn_d = REQ_I.wdata[`PIN_FN_MSB:`PIN_FN_LSB];
      end
      if (REQ_I.rd_en) begin
         case (REQ_I.addr)
            `FILTER_POLE_SELECT_ADDR: rdata_d = filter_q;
            `SHARED_PIN_FUNCTION_CTRL_ADDR: rdata_d = {6'h00, pin_fn_q};
            default: rdata_d = 8'h00;
         endcase
      end
   end

   // new data wins over a read in the same cycle so no sample is lost
   always_comb begin
      ready_d = ready_q;
      if (RATE_DATA_READ_I) begin
         ready_d = 1'b0;
      end
      if (NEW_DATA_I) begin
         ready_d = 1'b1;
      end
      pin_o_d = 1'b0;
      oe_n_d = 1'b1;
      analog_d = analog_q;
      case (mode)
         PIN_DRIVE_READY: begin
            pin_o_d = ready_d;
            oe_n_d = 1'b0;
         end
         PIN_SENSE: analog_d = SHARED_SELECT_PIN_I;
         default: oe_n_d = 1'b1;
      endcase
   end

   always_ff @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         filter_q <= `FILTER_POLE_SELECT_RESET;
         pin_fn_q <= 2'h0;
         ready_q <= 1'b0;
         rdata_q <= 8'h00;
         pin_o_q <= 1'b0;
         oe_n_q <= 1'b1;
         analog_q <= 1'b0;
      end else begin
         filter_q <= filter_d;
         pin_fn_q <= pin_fn_d;
         ready_q <= ready_d;
         rdata_q <= rdata_d;
         pin_o_q <= pin_o_d;
         oe_n_q <= oe_n_d;
         analog_q <= analog_d;
      end
   end

   assign RDATA_O = rdata_q;
   // the filter datapath lives elsewhere; it takes the pole codes as they stand
   assign HIGHPASS_POLE_SEL_O = filter_q.highpass_pole_sel;
   assign LOWPASS_POLE_SEL_O = filter_q.lowpass_pole_sel;
   assign SHARED_SELECT_PIN_O = pin_o_q;
   assign SHARED_SELECT_PIN_OE_N_O = oe_n_q;
   assign ANALOG_ENABLE_O = analog_q;

   default clocking cb @(posedge CORE_CLK_I); endclocking
   default disable iff (RST_I);

   filter_write_a: assert property (
      REQ_I.wr_en && REQ_I.addr == 8'h11 |=> filter_q == {$past(REQ_I.wdata[7:4]), 1'b0,
         $past(REQ_I.wdata[2:0])})
      else $error("filter byte not written");
   filter_zero_a: assert property (filter_q.zero_bit == 1'b0)
      else $error("filter bit 3 not zero");
   lowpass_out_a: assert property (LOWPASS_POLE_SEL_O == filter_q[2:0])
      else $error("low-pass select mismatch");
   highpass_out_a: assert property (
      REQ_I.wr_en && REQ_I.addr == 8'h11 |=> HIGHPASS_POLE_SEL_O == $past(REQ_I.wdata[7:4]))
      else $error("high-pass select mismatch");
   pinfn_read_a: assert property (
      REQ_I.rd_en && REQ_I.addr == 8'h12 |=> RDATA_O == {6'h00, $past(pin_fn_q)})
      else $error("pin-function readback wrong");
   ready_drive_a: assert property (
      pin_fn_q == 2'h1 && NEW_DATA_I && pin_fn_d == 2'h1 |=> !oe_n_q && pin_o_q)
      else $error("data-ready not driven");
   ready_hold_a: assert property (
      ready_q && !RATE_DATA_READ_I |=> ready_q)
      else $error("data-ready dropped before read");
   ready_clear_a: assert property (
      RATE_DATA_READ_I && !NEW_DATA_I |=> !ready_q)
      else $error("data-ready not cleared by read");
   sense_mode_a: assert property (
      pin_fn_q[0] == 1'b0 |=> oe_n_q)
      else $error("pin driven in sense mode");
   reset_zero_a: assert property (
      @(posedge CORE_CLK_I) disable iff (1'b0) $past(RST_I) |-> filter_q == 8'h00 && pin_fn_q == 2'h0)
      else $error("bytes not zero after reset");
   reset_outputs_a: assert property (
      @(posedge CORE_CLK_I) disable iff (1'b0)
      $past(RST_I) |-> oe_n_q && !pin_o_q && !ready_q && RDATA_O == 8'h00)
      else $error("outputs not idle after reset");
   filter_read_a: assert property (
      REQ_I.rd_en && REQ_I.addr == 8'h11 |=> RDATA_O == $past(filter_q))
      else $error("filter readback wrong");
   filter_keep_a: assert property (
      !(REQ_I.wr_en && REQ_I.addr == 8'h11) |=> $stable(filter_q))
      else $error("filter byte changed without write");
   lowpass_write_a: assert property (
      REQ_I.wr_en && REQ_I.addr == 8'h11 |=> LOWPASS_POLE_SEL_O == $past(REQ_I.wdata[2:0]))
      else $error("low-pass select not written");
   pinfn_write_a: assert property (
      REQ_I.wr_en && REQ_I.addr == 8'h12 |=> pin_fn_q == $past(REQ_I.wdata[1:0]))
      else $error("pin-function select not written");
   pinfn_high_a: assert property (
      REQ_I.rd_en && REQ_I.addr == 8'h12 |=> RDATA_O[7:2] == 6'h00)
      else $error("pin-function upper bits not zero");
   rdata_idle_a: assert property (
      !REQ_I.rd_en |=> RDATA_O == 8'h00)
      else $error("read data not idle");
   unmapped_read_a: assert property (
      REQ_I.rd_en && REQ_I.addr != 8'h11 && REQ_I.addr != 8'h12
      |=> RDATA_O == 8'h00)
      else $error("unmapped read not zero");
   ready_oe_a: assert property (
      pin_fn_q == 2'h1 && pin_fn_d == 2'h1 |=> !oe_n_q)
      else $error("pad not enabled in data-ready mode");
   ready_follow_a: assert property (
      pin_fn_q == 2'h1 && pin_fn_d == 2'h1 |=> SHARED_SELECT_PIN_O == ready_q)
      else $error("pad does not show data-ready level");
   set_wins_a: assert property (
      NEW_DATA_I && RATE_DATA_READ_I |=> ready_q)
      else $error("new data lost to same-cycle read");
   sense_track_a: assert property (
      pin_fn_q[0] == 1'b0 |=> ANALOG_ENABLE_O == $past(SHARED_SELECT_PIN_I))
      else $error("analog enable not tracking pad");
   reserved_release_a: assert property (
      pin_fn_q == 2'h3 |=> oe_n_q && !pin_o_q)
      else $error("pad driven in reserved mode");
   reserved_hold_a: assert property (
      pin_fn_q == 2'h3 |=> ANALOG_ENABLE_O == $past(ANALOG_ENABLE_O))
      else $error("analog enable moved in reserved mode");

   // covers show the main paths were reached, not that they are right
   ready_cycle_c: cover property (NEW_DATA_I ##[1:5] RATE_DATA_READ_I);
   reserved_c: cover property (pin_fn_q == 2'h3 && oe_n_q);
   mode_ready_c: cover property (pin_fn_q == 2'h1 && pin_o_q);
   sense_c: cover property (pin_fn_q == 2'h2 && ANALOG_ENABLE_O);
   filter_wr_c: cover property (REQ_I.wr_en && REQ_I.addr == 8'h11);
endmodule
`default_nettype wire

/* bench/pad_model.sv */
// shared pad: device drives when enabled, else the board strap
`timescale 1ns/1ns
`default_nettype none
module pad_model (
   input wire logic oe_n_i,
   input wire logic dev_i,
   input wire logic strap_i,
   output logic pad_o
);
   // strap only wins while the device lets go
   assign pad_o = oe_n_i ? strap_i : dev_i;
endmodule
`default_nettype wire

/* bench/test_filt_ready_regs.sv */
// bench for the filter and data-ready register bank
`timescale 1ns/1ns
`default_nettype none
module test_filt_ready_regs;
   import filt_ready_pkg::*;
   logic clk = 0, rst = 1, nd = 0, rr = 0, strap = 0, pend = 0, pin, oe_n, dev, ae;
   reg_req_t req = '0;
   logic [7:0] rdata, v;
   logic [3:0] hp;
   logic [2:0] lp;
   logic [7:0] expq[$];
   int num_errors = 0, comparisons = 0;
   filt_ready_regs u_dut (.CORE_CLK_I(clk), .RST_I(rst), .REQ_I(req), .NEW_DATA_I(nd),
      .RATE_DATA_READ_I(rr), .SHARED_SELECT_PIN_I(pin), .RDATA_O(rdata),
      .HIGHPASS_POLE_SEL_O(hp), .LOWPASS_POLE_SEL_O(lp), .SHARED_SELECT_PIN_O(dev),
      .SHARED_SELECT_PIN_OE_N_O(oe_n), .ANALOG_ENABLE_O(ae));
   pad_model u_pad (.oe_n_i(oe_n), .dev_i(dev), .strap_i(strap), .pad_o(pin));
   initial forever #50 clk = ~clk;
   task chk(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task summarize;
      $display("%0d comparisons, %0d errors", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task acc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d,
      input logic [7:0] e);
      req = '{w, r, a, d};
      if (r) expq.push_back(e);
      @(posedge clk) #1 req = '0;
      @(posedge clk) #1;
   endtask
   // read data lands one edge after the strobe
   always @(posedge clk) pend <= req.rd_en;
   always @(negedge clk) if (pend) chk(rdata, expq.pop_front());
   initial begin
      #50000 num_errors++;
      summarize;
   end
   initial begin
      v = $urandom(32'h0215);
      repeat (16) @(posedge clk);
      #1 rst = 0;
      acc(0, 1, 8'h11, 8'h00, 8'h00);
      acc(0, 1, 8'h12, 8'h00, 8'h00);
      $display("reset values done");
      repeat (8) begin
         v = $urandom;
         acc(1, 0, 8'h11, v, 8'h00);
         acc(0, 1, 8'h11, 8'h00, v & 8'hF7);
         chk({hp, 1'b0, lp}, v & 8'hF7);
      end
      acc(1, 0, 8'h13, 8'hFF, 8'h00);
      acc(0, 1, 8'h13, 8'h00, 8'h00);
      acc(1, 0, 8'h12, 8'hFE, 8'h00);
      acc(0, 1, 8'h12, 8'h00, 8'h02);
      $display("filter and map done");
      strap = 1;
      repeat (2) @(posedge clk);
      #1 chk({6'h00, oe_n, ae}, 8'h03);
      acc(1, 0, 8'h12, 8'h01, 8'h00);
      nd = 1;
      @(posedge clk) #1 nd = 0;
      chk({6'h00, pin, oe_n}, 8'h02);
      repeat (3) @(posedge clk);
      #1 chk({6'h00, pin, oe_n}, 8'h02);
      rr = 1;
      @(posedge clk) #1 rr = 0;
      chk({6'h00, dev, oe_n}, 8'h00);
      $display("data ready done");
      acc(1, 0, 8'h12, 8'h03, 8'h00);
      acc(0, 1, 8'h12, 8'h00, 8'h03);
      strap = 0;
      repeat (2) @(posedge clk);
      #1 chk({6'h00, oe_n, ae}, 8'h03);
      $display("reserved code done");
      acc(1, 0, 8'h12, 8'h01, 8'h00);
      nd = 1;
      rr = 1;
      @(posedge clk) #1 nd = 0;
      rr = 0;
      chk({6'h00, pin, oe_n}, 8'h02);
      rr = 1;
      @(posedge clk) #1 rr = 0;
      chk({6'h00, dev, oe_n}, 8'h00);
      $display("set over clear done");
      acc(1, 0, 8'h12, 8'h00, 8'h00);
      repeat (2) @(posedge clk);
      #1 chk({6'h00, oe_n, ae}, 8'h02);
      $display("sense mode done");
      summarize;
   end
endmodule
`default_nettype wire
